// [rtl/wdu_pkg.sv]
package wdu_pkg;

  // Instruction words decoded by this block.
  localparam logic [11:0] WDU_OP_CLEAR_WDT = 12'h004;
  localparam logic [11:0] WDU_OP_LOAD_PRESCALER = 12'h002;
  localparam logic [11:0] WDU_OP_SLEEP = 12'h003;

  // Prescaler configuration register field positions and reset value.
  localparam int WDU_PS_LSB = 0;
  localparam int WDU_PS_MSB = 2;
  localparam int WDU_PSA_BIT = 3;
  localparam logic [7:0] WDU_CFG_RESET = 8'hFF;

  // Timing: nominal timeout and startup hold, both 18 ms, at a 20 MHz reference.
  localparam int WDU_CLK_HZ = 20000000;
  localparam int WDU_TIMEOUT_MS = 18;
  localparam int WDU_STARTUP_MS = 18;
  localparam int WDU_TIMEOUT_CYC = (WDU_CLK_HZ / 1000) * WDU_TIMEOUT_MS;
  localparam int WDU_STARTUP_CYC = (WDU_CLK_HZ / 1000) * WDU_STARTUP_MS;

  // Prescaler is eight bits wide, giving ratios 1:1 up to 1:128.
  localparam int WDU_PS_WIDTH = 8;

endpackage

// [rtl/wdu_prescaler.sv]
`timescale 1ns/1ps
// Shared synchronous prescaler; tick pulses once per 2**ratio input ticks.
module wdu_prescaler
  import wdu_pkg::*;
#(
  parameter int WIDTH = WDU_PS_WIDTH
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clr,
  input wire logic tick_in,
  input wire logic [2:0] ratio,
  output logic tick_out
);

  // Refuse a counter too narrow for the largest ratio.
  if (WIDTH < 7) begin : g_bad_width
    $error("prescaler width too small for 1:128");
  end

  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;
  logic tick_nxt;

  // Count input ticks and raise one output tick at the selected ratio.
  always_comb begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (clr) begin
      cnt_nxt = '0;
    end else if (tick_in) begin
      if (cnt_r >= ((WIDTH'(1) << ratio) - WIDTH'(1))) begin
        cnt_nxt = '0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + WIDTH'(1);
      end
    end
  end

  // Register the count and the tick.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
      tick_out <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_out <= tick_nxt;
    end
  end

endmodule

// [rtl/wdu_watchdog.sv]
`timescale 1ns/1ps
// What this block does
// [R1] Watchdog counts on its own free clock, independent of core clock or sleep.
// [R2] An enabled watchdog reaching timeout raises a full device reset.
// [R3] The enable fuse in disabled setting blocks every timeout forever.
// [R4] Without prescaler the timeout is about 18 ms.
// [R5] Software may assign the prescaler to the watchdog, extending it up to 1:128.
// [R6] Clear-watchdog and sleep zero the counter and an assigned prescaler.
// [R7] A timeout drives the active-low timeout flag to zero.
// [R8] Word 0x004 is clear-watchdog: zero counter and assigned prescaler, update both flags.
// [R9] Word 0x002 loads the working register into the prescaler config; flags stay.
// [R10] Sleep clears power-down flag, sets timeout flag, stops main oscillator.
// [R11] A timeout restarts the startup delay, holding reset about 18 ms.
// [R12] An enabled timeout wakes the halted device; timeout flag marks the cause.
// [R13] Three config bits pick ratio 1:1 to 1:128; one bit assigns prescaler.
// [R14] Clear-watchdog sets both timeout and power-down flags to one.
module wdu_watchdog
  import wdu_pkg::*;
#(
  parameter int TIMEOUT_CYC = WDU_TIMEOUT_CYC,
  parameter int STARTUP_CYC = WDU_STARTUP_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wdt_fuse_en,
  input wire logic instr_valid,
  input wire logic [11:0] instr_word,
  input wire logic [7:0] work_reg,
  output logic device_reset,
  output logic wake,
  output logic osc_run,
  output logic timeout_flag_n,
  output logic powerdown_flag_n,
  output logic [7:0] prescaler_cfg,
  output logic [23:0] watchdog_counter
);

  // Refuse counts that the 24-bit counters cannot hold.
  if (TIMEOUT_CYC < 2 || TIMEOUT_CYC > 24'hFFFFFF) begin : g_bad_timeout
    $error("bad TIMEOUT_CYC");
  end
  if (STARTUP_CYC < 1 || STARTUP_CYC > 24'hFFFFFF) begin : g_bad_startup
    $error("bad STARTUP_CYC");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fuse synchroniser and instruction decode.

  logic fuse_s1_r;
  logic fuse_s2_r;
  logic clear_watchdog_instr;
  logic load_cfg_instr;
  logic sleep_instr;
  logic assigned;
  logic ps_tick;
  logic wdt_tick;
  logic timeout_evt;

  // The fuse is a pin: two flops before it is used.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fuse_s1_r <= 1'b0;
      fuse_s2_r <= 1'b0;
    end else begin
      fuse_s1_r <= wdt_fuse_en;
      fuse_s2_r <= fuse_s1_r;
    end
  end

  // Decode the two instructions this block owns plus sleep.
  assign clear_watchdog_instr = instr_valid && (instr_word == WDU_OP_CLEAR_WDT); // R8
  assign load_cfg_instr = instr_valid && (instr_word == WDU_OP_LOAD_PRESCALER); // R9
  assign sleep_instr = instr_valid && (instr_word == WDU_OP_SLEEP);
  assign assigned = prescaler_cfg[WDU_PSA_BIT]; // R13

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and watchdog counter.

  // Prescaler always divides the free base tick; cleared with the watchdog only when assigned.
  wdu_prescaler #(.WIDTH(WDU_PS_WIDTH)) u_ps (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clr((clear_watchdog_instr || sleep_instr) && assigned), // R6
    .tick_in(1'b1),
    .ratio(prescaler_cfg[WDU_PS_MSB:WDU_PS_LSB]), // R13
    .tick_out(ps_tick)
  );

  // Counter advances every cycle, or on prescaler ticks when assigned.
  assign wdt_tick = assigned ? ps_tick : 1'b1; // R5
  assign timeout_evt = fuse_s2_r && wdt_tick && (watchdog_counter == 24'(TIMEOUT_CYC - 1)); // R3 R4

  logic [23:0] cnt_nxt;
  logic [7:0] cfg_nxt;

  // Counter keeps running regardless of sleep or oscillator state.
  always_comb begin
    cnt_nxt = watchdog_counter; // R1
    cfg_nxt = prescaler_cfg;
    if (clear_watchdog_instr || sleep_instr || !fuse_s2_r || timeout_evt) begin
      cnt_nxt = '0; // R6
    end else if (wdt_tick) begin
      cnt_nxt = watchdog_counter + 24'h000001;
    end
    if (load_cfg_instr) begin
      cfg_nxt = work_reg; // R9
    end
  end

  // Register counter and configuration.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      watchdog_counter <= '0;
      prescaler_cfg <= WDU_CFG_RESET;
    end else begin
      watchdog_counter <= cnt_nxt;
      prescaler_cfg <= cfg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags, sleep, startup hold and reset output.

  logic asleep_r;
  logic asleep_nxt;
  logic [23:0] hold_r;
  logic [23:0] hold_nxt;
  logic to_nxt;
  logic pd_nxt;
  logic rst_nxt;
  logic wake_nxt;
  logic osc_nxt;

  // Timeout wins over same-cycle instruction updates of timeout flag and sleep state; power-down flag keeps the instruction's value.
  always_comb begin
    to_nxt = timeout_flag_n;
    pd_nxt = powerdown_flag_n;
    asleep_nxt = asleep_r;
    hold_nxt = hold_r;
    wake_nxt = 1'b0;
    if (clear_watchdog_instr) begin
      to_nxt = 1'b1; // R14
      pd_nxt = 1'b1; // R14
    end else if (sleep_instr) begin
      to_nxt = 1'b1; // R10
      pd_nxt = 1'b0; // R10
      asleep_nxt = 1'b1; // R10
    end
    if (hold_r != 24'h000000) begin
      hold_nxt = hold_r - 24'h000001;
    end
    if (timeout_evt) begin
      to_nxt = 1'b0; // R7
      hold_nxt = 24'(STARTUP_CYC); // R11
      wake_nxt = asleep_r; // R12
      asleep_nxt = 1'b0;
    end
    rst_nxt = (hold_nxt != 24'h000000); // R2
    osc_nxt = !asleep_nxt; // R10
  end

  // Register flags and outputs.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      timeout_flag_n <= 1'b1;
      powerdown_flag_n <= 1'b1;
      asleep_r <= 1'b0;
      hold_r <= '0;
      device_reset <= 1'b0;
      wake <= 1'b0;
      osc_run <= 1'b1;
    end else begin
      timeout_flag_n <= to_nxt;
      powerdown_flag_n <= pd_nxt;
      asleep_r <= asleep_nxt;
      hold_r <= hold_nxt;
      device_reset <= rst_nxt;
      wake <= wake_nxt;
      osc_run <= osc_nxt; // R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hold length helper, read only by the checks below.

  logic [23:0] hold_len_r;
  logic [23:0] hold_len_nxt;

  // Counts consecutive cycles in which the device reset output stands high.
  always_comb begin
    hold_len_nxt = device_reset ? (hold_len_r + 24'h000001) : 24'h000000;
  end

  // Register the hold length.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hold_len_r <= '0;
    end else begin
      hold_len_r <= hold_len_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  AST_TIMEOUT_RESET: assert property (@(posedge ref_clk) disable iff (!nrst) // R2
    timeout_evt |=> device_reset && !timeout_flag_n) else $error("timeout did not reset");
  AST_RESET_CAUSE: assert property (@(posedge ref_clk) disable iff (!nrst) // R2
    $rose(device_reset) |-> $past(timeout_evt)) else $error("reset without timeout");
  AST_FUSE_OFF: assert property (@(posedge ref_clk) disable iff (!nrst) // R3
    !fuse_s2_r |=> watchdog_counter == 24'h000000) else $error("counter ran while fuse off");
  AST_CLEAR_ZERO: assert property (@(posedge ref_clk) disable iff (!nrst) // R6
    (clear_watchdog_instr || sleep_instr) |=> watchdog_counter == 24'h000000) else $error("clear failed");
  AST_PS_STEP: assert property (@(posedge ref_clk) disable iff (!nrst) // R5
    (fuse_s2_r && assigned && !ps_tick && !clear_watchdog_instr && !sleep_instr)
    |=> $stable(watchdog_counter)) else $error("counter moved without prescaler tick");
  AST_FLAG_CAUSE: assert property (@(posedge ref_clk) disable iff (!nrst) // R7
    $fell(timeout_flag_n) |-> $past(timeout_evt)) else $error("timeout flag fell without timeout");
  AST_CLEAR_FLAGS: assert property (@(posedge ref_clk) disable iff (!nrst) // R14
    (clear_watchdog_instr && !timeout_evt) |=> timeout_flag_n && powerdown_flag_n) else $error("flags wrong");
  AST_SLEEP_FLAGS: assert property (@(posedge ref_clk) disable iff (!nrst) // R10
    (sleep_instr && !timeout_evt) |=> !powerdown_flag_n && !osc_run) else $error("sleep wrong");
  AST_LOAD_CFG: assert property (@(posedge ref_clk) disable iff (!nrst) // R9
    (load_cfg_instr && !timeout_evt) |=> prescaler_cfg == $past(work_reg) && $stable(timeout_flag_n)
    && $stable(powerdown_flag_n)) else $error("load wrong");
  AST_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst) // R11
    timeout_evt |=> device_reset [*8]) else $error("hold too short");
  AST_HOLD_LEN: assert property (@(posedge ref_clk) disable iff (!nrst) // R11
    $fell(device_reset) |-> hold_len_r >= 24'(STARTUP_CYC)) else $error("startup hold ended early");
  AST_WAKE: assert property (@(posedge ref_clk) disable iff (!nrst) // R12
    (timeout_evt && asleep_r) |=> wake && osc_run) else $error("no wake");
  AST_WAKE_FLAG: assert property (@(posedge ref_clk) disable iff (!nrst) // R12
    wake |-> !timeout_flag_n && device_reset) else $error("wake without timeout mark");
  AST_RUN_ASLEEP: assert property (@(posedge ref_clk) disable iff (!nrst) // R1
    (asleep_r && fuse_s2_r && !assigned && !sleep_instr && !clear_watchdog_instr && !timeout_evt)
    |=> watchdog_counter == $past(watchdog_counter) + 24'h000001) else $error("stalled");

endmodule

// [test/wdu_core_model.sv]
`timescale 1ns/1ps
// Core side: passes one instruction per request, stalls while held in reset or asleep.
module wdu_core_model (
  input wire logic go,
  input wire logic [11:0] word,
  input wire logic [7:0] wreg,
  input wire logic device_reset,
  input wire logic osc_run,
  output logic instr_valid,
  output logic [11:0] instr_word,
  output logic [7:0] work_reg
);
  // A halted or reset core executes nothing; idle buses show inverted values.
  assign instr_valid = go & ~device_reset & osc_run;
  assign instr_word = go ? word : ~word;
  assign work_reg = go ? wreg : ~wreg;
endmodule

// [test/watchdog_timer_unit_tb.sv]
`timescale 1ns/1ps
module watchdog_timer_unit_tb;
  import wdu_pkg::*;
  localparam int TO_CYC = 20;
  localparam int ST_CYC = 10;
  logic ref_clk, nrst, fuse, go, instr_valid, device_reset, wake, osc_run, to_n, pd_n;
  logic [11:0] word, instr_word, w;
  logic [7:0] wreg, work_reg, cfg, v;
  logic [23:0] cnt;
  logic [2:0] r;
  int failures, n_compared, cycles, seed, k, n_rst;

  wdu_core_model u_core (.go(go), .word(word), .wreg(wreg), .device_reset(device_reset),
    .osc_run(osc_run), .instr_valid(instr_valid), .instr_word(instr_word), .work_reg(work_reg));
  wdu_watchdog #(.TIMEOUT_CYC(TO_CYC), .STARTUP_CYC(ST_CYC)) u_dut (.ref_clk(ref_clk), .nrst(nrst),
    .wdt_fuse_en(fuse), .instr_valid(instr_valid), .instr_word(instr_word), .work_reg(work_reg),
    .device_reset(device_reset), .wake(wake), .osc_run(osc_run), .timeout_flag_n(to_n),
    .powerdown_flag_n(pd_n), .prescaler_cfg(cfg), .watchdog_counter(cnt));

  ////////////////////////////////////////////////////////////////////////
  // Clock, reset counter and hang limit.
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge device_reset) n_rst++;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 20000) begin
      failures++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Compares one value and reports a mismatch.
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask

  // Issues one instruction for one cycle and lets its answer land.
  task automatic issue(input logic [11:0] iw, input logic [7:0] rv);
    @(negedge ref_clk);
    go = 1'b1;
    word = iw;
    wreg = rv;
    @(negedge ref_clk);
    go = 1'b0;
    @(negedge ref_clk);
  endtask

  // Counts cycles while device reset holds the given level, up to a limit.
  task automatic wait_lvl(input logic lvl, input int lim, output int c);
    c = 0;
    while (device_reset === lvl && c < lim) begin
      @(negedge ref_clk);
      c++;
    end
  endtask

  // Loads the config, clears, then times the timeout and the startup hold.
  task automatic run_timeout(input logic [7:0] cv, input int per);
    logic old_to;
    old_to = to_n;
    issue(WDU_OP_LOAD_PRESCALER, cv);
    check("config", cv, cfg);
    check("timeout flag kept", old_to, to_n);
    issue(WDU_OP_CLEAR_WDT, 8'h00);
    check("flags after clear", 2'b11, {to_n, pd_n});
    wait_lvl(1'b0, per * 2 + 10, k);
    check("timeout period ok", 1'b1, k >= per - 4 && k <= per + per / TO_CYC + 3);
    check("timeout flag", 1'b0, to_n);
    wait_lvl(1'b1, 100, k);
    check("startup hold ok", 1'b1, k >= ST_CYC - 1 && k <= ST_CYC + 1);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    seed = 38227;
    nrst = 1'b0;
    fuse = 1'b1;
    go = 1'b0;
    word = 12'h000;
    wreg = 8'h00;
    repeat (2) @(negedge ref_clk);
    check("reset state", 13'h1FFC, {cfg, to_n, pd_n, osc_run, device_reset, wake});
    nrst = 1'b1;
    repeat (3) @(negedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      w = 12'($random(seed));
      if (w inside {WDU_OP_CLEAR_WDT, WDU_OP_LOAD_PRESCALER, WDU_OP_SLEEP}) w = 12'hFFF;
      issue(w, 8'h5A);
      check("config kept", 8'hFF, cfg);
    end
    for (int i = 0; i < 4; i++) begin
      r = 3'($unsigned($random(seed)) % 8);
      v = {4'($random(seed)), i != 0, r};
      run_timeout(v, (i != 0) ? (TO_CYC << r) : TO_CYC);
    end
    k = n_rst;
    issue(WDU_OP_LOAD_PRESCALER, 8'h00);
    for (int i = 0; i < 6; i++) begin
      issue(WDU_OP_CLEAR_WDT, 8'h00);
      repeat (12) @(negedge ref_clk);
    end
    check("no timeout while cleared", k, n_rst);
    issue(WDU_OP_SLEEP, 8'h00);
    check("sleep state", 3'b100, {to_n, pd_n, osc_run});
    check("count restarted by sleep", 24'h000001, cnt);
    wait_lvl(1'b0, 60, k);
    check("sleep restarts count", 1'b1, k >= TO_CYC - 5 && k <= TO_CYC + 3);
    check("wake pulse", 2'b10, {wake, to_n});
    wait_lvl(1'b1, 100, k);
    check("running after wake", 1'b1, osc_run);
    check("wake ended", 1'b0, wake);
    fuse = 1'b0;
    k = n_rst;
    issue(WDU_OP_CLEAR_WDT, 8'h00);
    repeat (200) @(negedge ref_clk);
    check("fuse blocks timeout", k, n_rst);
    check("count held with fuse off", 24'h000000, cnt);
    nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    check("reset state again", 13'h1FFC, {cfg, to_n, pd_n, osc_run, device_reset, wake});
    nrst = 1'b1;
    repeat (3) @(negedge ref_clk);
    wrap_up();
  end
endmodule
